// ### src/bsw_ctrl.sv
// module: battery switch and input voltage limit tracking control bank
`timescale 1ns/10ps
module bsw_ctrl #(
	parameter longint     DELAY_CYCLES   = bsw_pkg::DELAY_CYCLES,
	parameter logic [7:0] TRACK_OFS_10_MV = 8'h fa,
	parameter logic [7:0] TRACK_OFS_11_MV = 8'h ff,
	parameter int         VW             = 14
) (
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          rstn,
	// register port
	input  wire logic [3:0]    reg_addr,
	input  wire logic [7:0]    reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [7:0]    reg_rdata,
	// resets from the rest of the unit
	input  wire logic          reg_reset,
	input  wire logic          watchdog_reset,
	// analog interface, millivolts
	input  wire logic [VW-1:0] battery_mv,
	output logic      [VW-1:0] input_voltage_limit,
	// switch control
	output logic               battery_switch_on,
	output logic               switch_reset_function_enable
);
	logic [7:0]    ctrl;
	logic [7:0]    next_ctrl;
	logic [7:0]    limit_reg;
	logic [7:0]    next_limit_reg;
	logic [7:0]    rdata;
	logic [7:0]    next_rdata;
	logic [VW-1:0] limit;
	logic [VW-1:0] next_limit;
	logic [VW-1:0] ofs;
	logic [VW-1:0] tracked;
	logic [VW:0]   track_sum;
	logic [VW-1:0] prog_mv;
	bsw_pkg::bsw_track_type trk;
	bsw_if         sw ();

	// register bank; reset inputs come from same-clock logic
	always_comb
	begin
		next_ctrl      = ctrl;
		next_limit_reg = limit_reg;
		if (reg_wr && reg_addr == bsw_pkg::ADDR_CTRL)
			next_ctrl = reg_wdata;
		if (reg_wr && reg_addr == bsw_pkg::ADDR_LIMIT)
			next_limit_reg = reg_wdata;
		if (watchdog_reset)
			next_ctrl[bsw_pkg::POS_RST_EN] = 1'b1; // [RL3]
		if (reg_reset)
		begin
			next_ctrl      = bsw_pkg::CTRL_RESET; // [RL3]
			next_limit_reg = bsw_pkg::LIMIT_RESET;
		end
		next_rdata = 8'h00;
		if (reg_rd)
		begin
			unique case (reg_addr)
				bsw_pkg::ADDR_CTRL:   next_rdata = ctrl;
				bsw_pkg::ADDR_LIMIT:  next_rdata = limit_reg;
				bsw_pkg::ADDR_STATUS: next_rdata = {7'h00, sw.switch_on};
				default:              next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl      <= bsw_pkg::CTRL_RESET;
			limit_reg <= bsw_pkg::LIMIT_RESET;
			rdata     <= 8'h00;
		end
		else
		begin
			ctrl      <= next_ctrl;
			limit_reg <= next_limit_reg;
			rdata     <= next_rdata;
		end
	end

	assign sw.disable_req = ctrl[bsw_pkg::POS_DISABLE]; // [RL6]
	assign sw.delay_sel   = ctrl[bsw_pkg::POS_DELAY_SEL];
	assign trk = bsw_pkg::bsw_track_type'(ctrl[bsw_pkg::POS_TRACK +: 2]);

	bsw_off_timer #(
		.DELAY_CYCLES (DELAY_CYCLES)
	) u_timer (
		.core_clk (core_clk),
		.rstn     (rstn),
		.ctl      (sw)
	);

	// limit register: 3.9 V base plus 100 mV per step
	assign prog_mv = VW'(bsw_pkg::LIMIT_BASE_MV)
		+ VW'(limit_reg[4:0]) * VW'(bsw_pkg::LIMIT_STEP_MV);

	always_comb
	begin
		unique case (trk)
			bsw_pkg::BSW_TRACK_OFF: ofs = '0;
			bsw_pkg::BSW_TRACK_200: ofs = VW'(bsw_pkg::TRACK_OFS_01_MV); // [RL4]
			bsw_pkg::BSW_TRACK_B:   ofs = VW'(TRACK_OFS_10_MV); // [RL7]
			bsw_pkg::BSW_TRACK_C:   ofs = VW'(TRACK_OFS_11_MV); // [RL7]
		endcase
		track_sum  = {1'b0, battery_mv} + {1'b0, ofs};
		// saturate so a high battery reading cannot wrap to a low limit
		tracked    = track_sum[VW] ? '1 : track_sum[VW-1:0];
		next_limit = prog_mv; // [RL4]
		if (trk != bsw_pkg::BSW_TRACK_OFF && tracked > prog_mv)
			next_limit = tracked; // [RL5]
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			limit <= '0;
		else
			limit <= next_limit;
	end

	assign reg_rdata                    = rdata;
	assign input_voltage_limit          = limit;
	assign battery_switch_on            = sw.switch_on;
	assign switch_reset_function_enable = ctrl[bsw_pkg::POS_RST_EN]; // [RL3]
endmodule : bsw_ctrl

// ### src/bsw_pkg.sv
// package: constants for the battery switch and voltage limit tracking block
// Operation
// RL1 - off-delay select 0: open battery switch at once when disable is set
// RL2 - off-delay select 1 (default): open switch after about 10 s
// RL3 - switch reset enable gates reset function; default 1, restored on resets
// RL4 - tracking field 00 (default) uses register limit; 01 adds 200 mV
// RL5 - tracking active: limit is max of register value and battery plus offset
// RL6 - disable bit 1 requests switch off, delayed only when off-delay select is 1; 0 permits switch on
// RL7 - tracking codes 10 and 11 use configurable offsets
package bsw_pkg;
	localparam logic [3:0] ADDR_CTRL       = 4'h7;
	localparam logic [3:0] ADDR_LIMIT      = 4'h6;
	localparam logic [3:0] ADDR_STATUS     = 4'h8;
	localparam int         POS_DISABLE     = 5;
	localparam int         POS_DELAY_SEL   = 3;
	localparam int         POS_RST_EN      = 2;
	localparam int         POS_TRACK       = 0;
	localparam logic [7:0] CTRL_RESET      = 8'h0c;
	localparam logic [7:0] LIMIT_RESET     = 8'h00;
	localparam int         DELAY_TIME_S    = 10;
	localparam longint     CLK_HZ          = 100000000;
	localparam longint     DELAY_CYCLES    = DELAY_TIME_S * CLK_HZ;
	localparam logic [7:0] TRACK_OFS_01_MV = 8'h c8;
	// scale of the limit register field, kept here so it can be retuned
	localparam int         LIMIT_BASE_MV   = 3900;
	localparam int         LIMIT_STEP_MV   = 100;
	typedef enum logic [1:0] {
		BSW_TRACK_OFF,
		BSW_TRACK_200,
		BSW_TRACK_B,
		BSW_TRACK_C
	} bsw_track_type;
endpackage : bsw_pkg

// ### src/bsw_if.sv
// interface: control bits passed from register bank to switch timer
`timescale 1ns/10ps
interface bsw_if;
	logic disable_req;
	logic delay_sel;
	logic switch_on;
	modport bank (output disable_req, output delay_sel, input switch_on);
	modport timer (input disable_req, input delay_sel, output switch_on);
endinterface : bsw_if

// ### src/bsw_off_timer.sv
// module: battery switch turn-off delay timer
`timescale 1ns/10ps
module bsw_off_timer #(
	parameter longint DELAY_CYCLES = bsw_pkg::DELAY_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// control
	bsw_if.timer     ctl
);
	localparam int CW = $clog2(DELAY_CYCLES + 1);
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          switch_on;
	logic          next_switch_on;

	always_comb
	begin
		next_count     = '0;
		next_switch_on = 1'b1;
		if (ctl.disable_req)
		begin
			if (!ctl.delay_sel)
				next_switch_on = 1'b0; // [RL1]
			else if (count >= CW'(DELAY_CYCLES - 1))
			begin
				next_count     = count;
				next_switch_on = 1'b0; // [RL2]
			end
			else
			begin
				next_count     = count + 1'b1;
				next_switch_on = switch_on; // [RL2]
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			count     <= '0;
			switch_on <= 1'b1;
		end
		else
		begin
			count     <= next_count;
			switch_on <= next_switch_on;
		end
	end

	assign ctl.switch_on = switch_on;
endmodule : bsw_off_timer

// ### sim/bsw_ctrl_asserts.sv
// checker: port-level properties of the switch control bank
`timescale 1ns/10ps
module bsw_chk #(
	parameter logic [7:0] TRACK_OFS_10_MV = 8'hfa
) (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rstn,
	// register port and resets
	input wire logic        reg_wr,
	input wire logic        reg_reset,
	input wire logic        watchdog_reset,
	input wire logic [3:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	// analog and switch
	input wire logic [13:0] battery_mv,
	input wire logic [13:0] input_voltage_limit,
	input wire logic        battery_switch_on,
	input wire logic        switch_reset_function_enable
);
	logic [1:0] trk;
	logic       wc;
	// shadow of the tracking field, as the bank does not show it at a port
	assign wc = reg_wr && reg_addr == 4'h7 && !reg_reset;
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			trk <= 2'h0;
		else if (reg_reset || wc)
			trk <= wc ? reg_wdata[1:0] : 2'h0;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_now; wc && reg_wdata[5] && !reg_wdata[3]
		|-> ##[1:2] !battery_switch_on; endproperty
	a_now: assert property (p_now) else $error("switch late");
	property p_hold; wc && reg_wdata[5] && reg_wdata[3] && battery_switch_on
		|=> battery_switch_on [*8]; endproperty
	a_hold: assert property (p_hold) else $error("switch early");
	property p_wdog; reg_reset || watchdog_reset
		|=> switch_reset_function_enable; endproperty
	a_wdog: assert property (p_wdog) else $error("enable lost");
	property p_off00; trk == 2'h0 && !reg_wr
		|=> input_voltage_limit <= 14'h1b58; endproperty
	a_off00: assert property (p_off00) else $error("tracking on");
	property p_trk; trk == 2'h1
		|=> input_voltage_limit >= $past(battery_mv) + 14'hc8; endproperty
	a_trk: assert property (p_trk) else $error("limit low");
	property p_on; wc && !reg_wdata[5] |-> ##[1:2] battery_switch_on; endproperty
	a_on: assert property (p_on) else $error("switch off");
	property p_ofs; trk == 2'h2 |=> input_voltage_limit
		>= $past(battery_mv) + 14'(TRACK_OFS_10_MV); endproperty
	a_ofs: assert property (p_ofs) else $error("offset low");
endmodule : bsw_chk

// ### sim/tb_top.sv
// testbench: register port, switch timing and limit tracking
`timescale 1ns/10ps
module tb_top;
	logic        core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        reg_reset = 1'b0, watchdog_reset = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata;
	logic [13:0] battery_mv = 14'h0, input_voltage_limit;
	logic        battery_switch_on, switch_reset_function_enable;
	int          n_errors = 0, compares = 0, cyc = 0;
	// code, limit field, battery, expected limit
	logic [37:0] rows [7] = '{{2'h0, 8'h00, 14'h1d4c, 14'hf3c},
		{2'h0, 8'h1f, 14'hbb8, 14'h1b58}, {2'h1, 8'h00, 14'hfa0, 14'h1068},
		{2'h1, 8'h0a, 14'hfa0, 14'h1324}, {2'h2, 8'h00, 14'hfa0, 14'h109a},
		{2'h3, 8'h00, 14'hfa0, 14'h109f}, {2'h3, 8'h1f, 14'hfa0, 14'h1b58}};
	// short delay so the timed turn-off fits the run
	bsw_ctrl #(
		.DELAY_CYCLES (20)
	) bsw_ctrl_i (
		.core_clk                     (core_clk),
		.rstn                         (rstn),
		.reg_addr                     (reg_addr),
		.reg_wdata                    (reg_wdata),
		.reg_wr                       (reg_wr),
		.reg_rd                       (reg_rd),
		.reg_rdata                    (reg_rdata),
		.reg_reset                    (reg_reset),
		.watchdog_reset               (watchdog_reset),
		.battery_mv                   (battery_mv),
		.input_voltage_limit          (input_voltage_limit),
		.battery_switch_on            (battery_switch_on),
		.switch_reset_function_enable (switch_reset_function_enable)
	);
	initial forever #5 core_clk = ~core_clk;
	task automatic complete_run;
		if (n_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	always @(posedge core_clk)
		if (++cyc == 3000)
		begin
			n_errors++;
			complete_run();
		end
	task automatic chk(input logic [13:0] s, input logic [13:0] e);
		compares++;
		if (s !== e)
		begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// the trailing delay keeps a strobe from being assigned twice at one edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(14'(reg_rdata), 14'(e));
	endtask : rd
	task automatic sw(input int n, input logic e);
		repeat (n) @(posedge core_clk);
		#1 chk(14'(battery_switch_on), 14'(e));
	endtask : sw
	initial
	begin
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		rd(4'h7, 8'h0c);
		foreach (rows[i])
		begin
			battery_mv <= rows[i][27:14];
			wr(4'h6, rows[i][35:28]);
			wr(4'h7, {6'h03, rows[i][37:36]});
			repeat (2) @(posedge core_clk);
			#1 chk(input_voltage_limit, rows[i][13:0]);
		end
		rd(4'h6, 8'h1f);
		wr(4'h7, 8'h24);
		sw(2, 1'b0);
		wr(4'h7, 8'h0c);
		sw(2, 1'b1);
		wr(4'h7, 8'h2c);
		repeat (12) @(posedge core_clk);
		wr(4'h7, 8'h0c);
		wr(4'h7, 8'h2c);
		sw(19, 1'b1);
		sw(1, 1'b0);
		wr(4'h7, 8'h03);
		rd(4'h7, 8'h03);
		chk(14'(switch_reset_function_enable), 14'h0000);
		watchdog_reset <= 1'b1;
		@(posedge core_clk);
		watchdog_reset <= 1'b0;
		rd(4'h7, 8'h07);
		chk(14'(switch_reset_function_enable), 14'h0001);
		reg_reset <= 1'b1;
		@(posedge core_clk);
		reg_reset <= 1'b0;
		rd(4'h7, 8'h0c);
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00);
		wr(4'h7, 8'h24);
		sw(3, 1'b0);
		// reset in mid-run: switch closes and limit clears at once
		rstn <= 1'b0;
		sw(2, 1'b1);
		chk(input_voltage_limit, 14'h0000);
		@(posedge core_clk);
		rstn <= 1'b1;
		rd(4'h7, 8'h0c);
		chk(input_voltage_limit, 14'hf3c);
		rd(4'h8, 8'h01);
		@(posedge core_clk);
		#1 chk(14'(reg_rdata), 14'h0000);
		complete_run();
	end
endmodule : tb_top
bind bsw_ctrl bsw_chk #(
	.TRACK_OFS_10_MV (TRACK_OFS_10_MV)
) bsw_chk_i (
	.core_clk                     (core_clk),
	.rstn                         (rstn),
	.reg_wr                       (reg_wr),
	.reg_reset                    (reg_reset),
	.watchdog_reset               (watchdog_reset),
	.reg_addr                     (reg_addr),
	.reg_wdata                    (reg_wdata),
	.battery_mv                   (battery_mv),
	.input_voltage_limit          (input_voltage_limit),
	.battery_switch_on            (battery_switch_on),
	.switch_reset_function_enable (switch_reset_function_enable)
);
